// ===== hdl/lps_pkg.sv
// package: constants and types of the latched pwm with shutdown and sync
package lps_pkg;

  // counter width of the oscillator phases and duty threshold
  localparam int CNT_W = 16;

  // reference clock period, ns
  localparam int CLK_PERIOD_NS = 10;
  // longest time from shutdown to outputs off, ns
  localparam int SHDN_MAX_NS = 200;
  // longest time from sync to discharge latched, ns
  localparam int SYNC_MAX_NS = 200;
  // longest times in cycles, rounded down
  localparam int SHDN_MAX_CYC = SHDN_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_MAX_CYC = SYNC_MAX_NS / CLK_PERIOD_NS;

  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] SS_RST = 16'h0000;
  localparam logic [16:0] SHCNT_RST = 17'h00000;

  // soft-start ramp: rise per cycle, fall per cycle, ceiling
  localparam logic [15:0] SS_STEP = 16'h0001;
  localparam logic [15:0] SS_DROP = 16'h0010;
  localparam logic [15:0] SS_FULL = 16'hffff;

  // period divisor that gives the short-shutdown limit
  localparam logic [16:0] THIRD_DIV = 17'h00003;
  // unit increment on the widened counters
  localparam logic [16:0] CNT_ONE = 17'h00001;

  // oscillator phase
  typedef enum logic [0:0] {
    LPS_CHARGE = 1'b0,
    LPS_DISCH = 1'b1
  } lps_osc_e;

  // timing configuration, in reference clock cycles
  typedef struct packed {
    logic [15:0] charge_len; // charge phase length
    logic [15:0] dead_len;   // discharge phase length (deadtime)
    logic [15:0] duty_thr;   // comparator threshold on the ramp
  } lps_cfg_s;

  // the two drive outputs
  typedef struct packed {
    logic drive_a;
    logic drive_b;
  } lps_drv_s;

endpackage

// ===== hdl/lps_pwm.sv
// latched pwm modulator: oscillator, latch, shutdown, soft-start, sync
//
// Summary of operation
// - shutdown forces both outputs off within 200 ns
// - shutdown sets latch; next clock clears it
// - shutdown under a third period keeps soft-start
// - held shutdown drains soft-start to zero
// - first comparator trip ends pulse, later ignored
// - shutdown uses own comparator input, threshold untouched
// - discharge phase holds clock high, outputs blanked
// - period is charge length plus deadtime length
// - sync pulse ends charge and starts discharge
// - sync latches fast; no charge while sync high
// - each output at half rate, duty below half
// - toggle steers successive periods to alternate outputs
// - both outputs driven low between pulses
`timescale 1ns/10ps
`default_nettype none

module lps_pwm
  import lps_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire lps_cfg_s i_cfg,
  input wire logic i_shutdown,
  input wire logic i_sync,
  output lps_drv_s o_drive,
  output logic o_osc_clk,
  output logic [15:0] o_softstart
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic shdn_m_ff; // first stage, read only by the second
  logic shdn_s_ff; // shutdown, clean
  logic sync_m_ff; // first stage, read only by the second
  logic sync_s_ff; // sync, clean

  // two flops per pin; the added 20 ns is well inside the 200 ns budget
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shdn_m_ff <= 1'b0;
      shdn_s_ff <= 1'b0;
      sync_m_ff <= 1'b0;
      sync_s_ff <= 1'b0;
    end else if (i_clk_en) begin
      shdn_m_ff <= i_shutdown;
      shdn_s_ff <= shdn_m_ff;
      sync_m_ff <= i_sync;
      sync_s_ff <= sync_m_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator

  lps_osc_e st_ff; // current phase
  lps_osc_e nxt_st;
  logic [15:0] cnt_ff; // cycles spent in the phase
  logic [15:0] nxt_cnt;
  logic steer_ff; // output steering toggle
  logic nxt_steer;
  logic chg_done; // charge length reached
  logic dis_done; // deadtime length reached

  // a zero length acts as one cycle, so the period never collapses
  assign chg_done = ({1'b0, cnt_ff} + CNT_ONE) >= {1'b0, i_cfg.charge_len};
  assign dis_done = ({1'b0, cnt_ff} + CNT_ONE) >= {1'b0, i_cfg.dead_len};

  // phase sequencing, period = charge + deadtime
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 16'h0001;
    nxt_steer = steer_ff;
    case (st_ff)
      LPS_CHARGE: begin
        // sync cuts the ramp short wherever it stands
        if (chg_done || sync_s_ff) begin
          nxt_st = LPS_DISCH;
          nxt_cnt = CNT_RST;
        end
      end
      LPS_DISCH: begin
        if (dis_done) begin
          if (sync_s_ff) begin
            // no recharge while sync stays high
            nxt_cnt = cnt_ff;
          end else begin
            nxt_st = LPS_CHARGE;
            nxt_cnt = CNT_RST;
            // each new period goes to the other output
            nxt_steer = ~steer_ff;
          end
        end
      end
      default: begin
        nxt_st = LPS_DISCH;
        nxt_cnt = CNT_RST;
      end
    endcase
  end

  // oscillator registers; start in discharge so the outputs stay blanked
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= LPS_DISCH;
      cnt_ff <= CNT_RST;
      steer_ff <= 1'b0;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      steer_ff <= nxt_steer;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // soft-start and shutdown duration

  logic [15:0] ss_ff; // soft-start ramp level
  logic [15:0] nxt_ss;
  logic [16:0] shcnt_ff; // cycles shutdown has been held
  logic [16:0] nxt_shcnt;
  logic [16:0] third; // a third of the configured period
  logic shdn_long; // shutdown held long enough to drain

  assign third = ({1'b0, i_cfg.charge_len} + {1'b0, i_cfg.dead_len})
                 / THIRD_DIV;
  assign shdn_long = shcnt_ff >= third;

  // the ramp only moves down once shutdown outlasts a third period
  always_comb begin
    nxt_shcnt = SHCNT_RST;
    nxt_ss = ss_ff;
    if (shdn_s_ff) begin
      // saturate so a very long shutdown cannot wrap the count
      if (shcnt_ff != 17'h1ffff) begin
        nxt_shcnt = shcnt_ff + CNT_ONE;
      end else begin
        nxt_shcnt = shcnt_ff;
      end
      if (shdn_long) begin
        // held shutdown bleeds the ramp to zero
        if (ss_ff > SS_DROP) begin
          nxt_ss = ss_ff - SS_DROP;
        end else begin
          nxt_ss = SS_RST;
        end
      end else begin
        // short pulse: the ramp is kept as it was
        nxt_ss = ss_ff;
      end
    end else if (ss_ff != SS_FULL) begin
      // ramp climbs again; from zero this is a full restart
      nxt_ss = ss_ff + SS_STEP;
    end
  end

  // soft-start registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ss_ff <= SS_RST;
      shcnt_ff <= SHCNT_RST;
    end else if (i_clk_en) begin
      ss_ff <= nxt_ss;
      shcnt_ff <= nxt_shcnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pwm latch and drive outputs

  logic lat_ff; // pulse termination latch
  logic nxt_lat;
  logic [15:0] eff_thr; // threshold limited by soft-start
  logic trip; // comparator output
  logic lat_set;
  logic lat_clr;
  lps_drv_s drv_ff; // registered drive outputs
  lps_drv_s nxt_drv;
  logic on_nxt; // a pulse is allowed in the next cycle

  // soft-start caps the threshold; the user threshold is never altered
  assign eff_thr = (ss_ff < i_cfg.duty_thr) ? ss_ff : i_cfg.duty_thr;
  // count reaching threshold trips the comparator
  assign trip = (st_ff == LPS_CHARGE) && (cnt_ff >= eff_thr);

  // shutdown enters as its own comparator term set wins
  always_comb begin
    lat_set = trip || shdn_s_ff;
    lat_clr = (st_ff == LPS_DISCH) && (nxt_st == LPS_CHARGE);
    // once set, further trips change nothing until the clock
    nxt_lat = lat_set || (lat_ff && !lat_clr);
  end

  // outputs follow the next phase so they line up with the state flops
  always_comb begin
    // blanked through discharge shutdown is direct
    on_nxt = (nxt_st == LPS_CHARGE) && !nxt_lat && !shdn_s_ff;
    // one side per period both low otherwise
    nxt_drv.drive_a = on_nxt && !nxt_steer;
    nxt_drv.drive_b = on_nxt && nxt_steer;
  end

  // latch and output registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lat_ff <= 1'b0;
      drv_ff <= '0;
    end else if (i_clk_en) begin
      lat_ff <= nxt_lat;
      drv_ff <= nxt_drv;
    end
  end

  assign o_drive = drv_ff;
  // clock output is the discharge phase itself
  assign o_osc_clk = (st_ff == LPS_DISCH);
  assign o_softstart = ss_ff;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  // shutdown held three cycles has the outputs off on the next one
  a_shdn_off_fast: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_shutdown) [*3] |=>
      (!o_drive.drive_a && !o_drive.drive_b))
    else $error("shutdown did not force outputs off in time");

  // the latch stays set until the clock pulse ends
  a_latch_holds: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (lat_ff && !(st_ff == LPS_DISCH && nxt_st == LPS_CHARGE)) |=> lat_ff)
    else $error("termination latch released inside a period");

  // a set latch means no pulse, whatever the comparator does
  a_trip_once: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    lat_ff |-> (!o_drive.drive_a && !o_drive.drive_b))
    else $error("output pulsed after termination");

  // once the pulse has ended, the rest of the charge phase stays dark
  a_pulse_once: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && st_ff == LPS_CHARGE && nxt_st == LPS_CHARGE &&
     !o_drive.drive_a && !o_drive.drive_b) |=>
      (!o_drive.drive_a && !o_drive.drive_b))
    else $error("second pulse inside one period");

  // discharge keeps the clock high and the outputs blank
  a_blank_disch: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (st_ff == LPS_DISCH) |->
      (o_osc_clk && !o_drive.drive_a && !o_drive.drive_b))
    else $error("outputs not blanked during discharge");

  // full charge length moves the oscillator into discharge
  a_charge_len: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && st_ff == LPS_CHARGE &&
     cnt_ff == i_cfg.charge_len - 16'h0001) |=>
      (st_ff == LPS_DISCH && cnt_ff == CNT_RST))
    else $error("charge phase length wrong");

  // sync seen on the pin reaches discharge within a few cycles
  a_sync_ends: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_sync) [*3] |=> (st_ff == LPS_DISCH))
    else $error("sync did not end the charge phase");

  // no recharge while the synchronised sync is high
  a_sync_holds: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (st_ff == LPS_DISCH && sync_s_ff) |=> (st_ff == LPS_DISCH))
    else $error("charge began while sync high");

  // steering flips exactly at each new charge phase
  a_steer_alt: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && st_ff == LPS_DISCH && nxt_st == LPS_CHARGE) |=>
      (steer_ff != $past(steer_ff)))
    else $error("steering did not alternate");

  // never both outputs at once
  a_one_side: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !(o_drive.drive_a && o_drive.drive_b))
    else $error("both outputs driven high");

  // a short shutdown leaves the ramp where it was
  a_ss_short: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && shdn_s_ff && !shdn_long) |=> $stable(ss_ff))
    else $error("short shutdown disturbed soft-start");

  // a long shutdown drains the ramp
  a_ss_drain: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && shdn_s_ff && shdn_long && ss_ff != SS_RST) |=>
      (ss_ff < $past(ss_ff)))
    else $error("held shutdown did not drain soft-start");

endmodule

`default_nettype wire

// ===== testbench/lps_stage.sv
// power stage model: watches the drive pair and counts pulses
`timescale 1ns/10ps
`default_nettype none

module lps_stage
  import lps_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire lps_drv_s i_drive,
  output logic o_overlap,
  output logic [7:0] o_pulses_a,
  output logic [7:0] o_pulses_b
);
  lps_drv_s last_ff; // previous drive pair, for edge detection

  ////////////////////////////////////////////////////////////////////////
  // sticky overlap flag: both switches on would short the supply
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_overlap <= 1'b0;
      o_pulses_a <= 8'h00;
      o_pulses_b <= 8'h00;
      last_ff <= '0;
    end else begin
      last_ff <= i_drive;
      if (i_drive.drive_a && i_drive.drive_b) begin
        o_overlap <= 1'b1;
      end
      // rising edges only, so a long pulse counts once
      if (i_drive.drive_a && !last_ff.drive_a) begin
        o_pulses_a <= o_pulses_a + 8'h01;
      end
      if (i_drive.drive_b && !last_ff.drive_b) begin
        o_pulses_b <= o_pulses_b + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ===== testbench/latched_pwm_shutdown_sync_test.sv
// testbench of the latched pwm with shutdown and sync
`timescale 1ns/10ps
`default_nettype none

module latched_pwm_shutdown_sync_test;
  import lps_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0; // active low reset
  logic i_clk_en = 1'b1; // low freezes the whole block
  logic i_shutdown = 1'b0;
  logic i_sync = 1'b0;
  lps_cfg_s i_cfg = '{16'h0014, 16'h0006, 16'h0008}; // 20/6/8 cycles
  lps_drv_s o_drive;
  logic o_osc_clk;
  logic [15:0] o_softstart;
  logic overlap;
  logic [7:0] pul_a;
  logic [7:0] pul_b;
  int n_fail = 0;
  int cmp_count = 0;
  int lo, hi, na, nb, bad, a1, b1, k;
  logic [15:0] ss;
  logic [7:0] pa0, pb0;

  always #5 i_ref_clk = ~i_ref_clk;

  lps_pwm lps_pwm_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_clk_en(i_clk_en), .i_cfg(i_cfg), .i_shutdown(i_shutdown),
    .i_sync(i_sync), .o_drive(o_drive), .o_osc_clk(o_osc_clk),
    .o_softstart(o_softstart));
  lps_stage lps_stage_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_drive(o_drive), .o_overlap(overlap), .o_pulses_a(pul_a),
    .o_pulses_b(pul_b));

  ////////////////////////////////////////////////////////////////////////
  // helpers; all driving and sampling 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      #1;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // bounded wait for the oscillator clock to reach a level
  task automatic wait_osc(input logic lvl);
    k = 0;
    while (o_osc_clk !== lvl && k < 200) begin
      step(1);
      k++;
    end
    check(o_osc_clk, lvl);
  endtask

  // one full period from charge start: phase lengths and pulse cycles
  task automatic period();
    lo = 0; hi = 0; na = 0; nb = 0; bad = 0;
    while (o_osc_clk === 1'b0 && lo < 200) begin
      na += (o_drive.drive_a === 1'b1);
      nb += (o_drive.drive_b === 1'b1);
      step(1);
      lo++;
    end
    while (o_osc_clk === 1'b1 && hi < 200) begin
      if (o_drive !== 2'b00) bad++;
      step(1);
      hi++;
    end
  endtask

  // wait for the next charge start, then measure that period
  task automatic measure();
    wait_osc(1'b1);
    wait_osc(1'b0);
    period();
  endtask

  // count cycles with any drive on until the charge phase ends
  task automatic off_rest();
    bad = 0;
    k = 0;
    while (o_osc_clk === 1'b0 && k < 200) begin
      if (o_drive !== 2'b00) bad++;
      step(1);
      k++;
    end
    check(k < 200, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_normal();
    pa0 = pul_a;
    pb0 = pul_b;
    measure();
    check(lo, 20);
    check(hi, 6);
    check(bad, 0);
    check(na + nb, 9);
    a1 = na;
    b1 = nb;
    // the very next period, which must go to the other output
    period();
    check(na, b1);
    check(nb, a1);
    check(pul_a - pa0, 8'h01);
    check(pul_b - pb0, 8'h01);
    check((a1 + na) * 2 < 52, 1);
    check(overlap, 1'b0);
  endtask

  // raising the threshold after the trip must not restart the pulse
  task automatic t_latch();
    wait_osc(1'b1);
    wait_osc(1'b0);
    step(12);
    check(o_drive, 2'b00);
    i_cfg.duty_thr = 16'hffff;
    off_rest();
    check(bad, 0);
    i_cfg.duty_thr = 16'h0008;
  endtask

  // one-cycle shutdown mid-pulse, well under a third of the period
  task automatic t_short_shdn();
    wait_osc(1'b1);
    wait_osc(1'b0);
    step(2);
    ss = o_softstart;
    i_shutdown = 1'b1;
    step(1);
    i_shutdown = 1'b0;
    k = 0;
    while (o_drive !== 2'b00 && k < SHDN_MAX_CYC) begin
      step(1);
      k++;
    end
    check(o_drive, 2'b00);
    off_rest();
    check(bad, 0);
    measure();
    check(na + nb, 9);
    check(o_softstart > ss, 1);
  endtask

  // sync from an outside source cuts the charge short and holds discharge
  task automatic t_sync();
    wait_osc(1'b1);
    wait_osc(1'b0);
    step(3);
    i_sync = 1'b1;
    k = 0;
    while (o_osc_clk !== 1'b1 && k < SYNC_MAX_CYC) begin
      step(1);
      k++;
    end
    check(o_osc_clk, 1'b1);
    check(o_drive, 2'b00);
    step(30);
    check(o_osc_clk, 1'b1);
    i_sync = 1'b0;
    step(8);
    check(o_osc_clk, 1'b0);
  endtask

  // a master clock slaves the oscillator: 22 cycles win over the free 26
  task automatic t_master();
    wait_osc(1'b1);
    wait_osc(1'b0);
    repeat (4) begin
      i_sync = 1'b1; // master every 22 cycles, slave 18% slower
      step(2);
      check(o_osc_clk, 1'b0);
      i_sync = 1'b0;
      step(1);
      check(o_osc_clk, 1'b1);
      check(o_drive, 2'b00);
      step(5);
      check(o_osc_clk, 1'b1);
      step(1);
      check(o_osc_clk, 1'b0);
      step(13);
    end
  endtask

  // clock enable low freezes the count, so the period stretches by the gap
  task automatic t_freeze();
    wait_osc(1'b1);
    wait_osc(1'b0);
    ss = o_softstart;
    i_clk_en = 1'b0;
    step(10);
    check(o_osc_clk, 1'b0);
    check(o_softstart, ss);
    i_clk_en = 1'b1;
    period();
    check(lo, 20);
    check(hi, 6);
    check(na + nb, 9);
  endtask

  // held shutdown drains the ramp; release restarts it from zero
  task automatic t_hold();
    i_shutdown = 1'b1;
    step(SHDN_MAX_CYC);
    check(o_drive, 2'b00);
    step(2000);
    check(o_softstart, 16'h0000);
    check(o_drive, 2'b00);
    i_shutdown = 1'b0;
    step(5);
    check(o_softstart < 16'h0010, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    step(8);
    check(o_drive, 2'b00);
    check(o_osc_clk, 1'b1);
    check(o_softstart, 16'h0000);
    i_nrst = 1'b1;
    step(40); // let the ramp pass the threshold
    t_normal();
    t_latch();
    t_short_shdn();
    t_sync();
    t_master();
    t_freeze();
    t_hold();
    end_of_test();
  end

  // watchdog: the sequence needs well under 4000 cycles
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule

`default_nettype wire
